// ### design/sadc_buf2.sv
// Purpose: Two-entry valid/ready buffer for conversion results
// Assumes: Single clock, clock enable freezes all state
// Notes: Full when both entries hold data; a word offered while full is not stored
`timescale 1ns/1ps
`default_nettype none
module sadc_buf2 #(
  parameter int W = 12
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  logic [W-1:0] mem_r [2];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] cnt_r;
  wire push = in_valid_i && (cnt_r != 2'h2);
  wire pop = out_ready_i && (cnt_r != 2'h0);

  assign in_ready_o = (cnt_r != 2'h2);
  assign out_valid_o = (cnt_r != 2'h0);
  assign out_data_o = mem_r[rd_ptr_r];

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r <= 2'h0;
    end
    else if (ce_i)
    begin
      if (push)
      begin
        mem_r[wr_ptr_r] <= in_data_i;
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop)
        rd_ptr_r <= ~rd_ptr_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // sadc_buf2
`default_nettype wire

// ### design/sadc_ctrl.sv
// Purpose: Conversion sequencing and serial readout of a 12-bit SAR converter
// Assumes: Pins convert_start_n and serial clock are asynchronous, sampled
//   through two flip-flops; the comparator code is sampled from sar_code_i at conversion end
// Notes: Serial data output enable is active low (low while driving)
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl #(
  parameter int CONV_CYC = sadc_pkg::CONV_CYC,
  parameter int WAKE_CYC = sadc_pkg::WAKE_CYC,
  parameter int ACQ_CYC = sadc_pkg::ACQ_CYC
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic convert_start_n_i,
  input wire logic serial_clk_i,
  input wire sadc_pkg::sadc_word_t sar_code_i,
  output logic serial_result_out_o,
  output logic serial_result_oe_n_o,
  output logic busy_o,
  output logic hold_o,
  output logic power_down_o,
  output logic acq_done_o,
  output sadc_pkg::sadc_word_t result_o,
  output logic result_valid_o,
  input wire logic result_ready_i
);
  localparam int CW = 16;
  localparam int RB = sadc_pkg::RES_BITS;
  localparam int FB = sadc_pkg::FRAME_BITS;

  // Two-stage synchronisers; stage one is read only by stage two
  logic cs_s1_r, cs_s2_r, cs_d_r;
  logic sc_s1_r, sc_s2_r, sc_d_r;

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_d_r <= 1'b1;
      sc_s1_r <= 1'b0;
      sc_s2_r <= 1'b0;
      sc_d_r <= 1'b0;
    end
    else if (ce_i)
    begin
      cs_s1_r <= convert_start_n_i;
      cs_s2_r <= cs_s1_r;
      cs_d_r <= cs_s2_r;
      sc_s1_r <= serial_clk_i;
      sc_s2_r <= sc_s1_r;
      sc_d_r <= sc_s2_r;
    end
  end

  wire cs_fall = cs_d_r && !cs_s2_r;
  wire cs_rise = !cs_d_r && cs_s2_r;
  wire sc_fall = sc_d_r && !sc_s2_r;

  sadc_pkg::sadc_state_t state_r, state_nxt;
  logic [CW-1:0] tmr_r, tmr_nxt;
  logic [CW-1:0] acq_r;
  sadc_pkg::sadc_word_t code_r;
  logic busy_r, hold_r, pd_r, acq_done_r;
  logic push_r;

  wire conv_end = (state_r == sadc_pkg::SADC_CONVERT) &&
                  (tmr_r == CW'(CONV_CYC - 1));
  wire wake_end = (state_r == sadc_pkg::SADC_WAKE) &&
                  (tmr_r == CW'(WAKE_CYC - 1));

  always_comb
  begin
    state_nxt = state_r;
    tmr_nxt = tmr_r + CW'(1);
    unique case (state_r)
      sadc_pkg::SADC_TRACK:
        if (cs_fall)
        begin
          state_nxt = sadc_pkg::SADC_CONVERT;
          tmr_nxt = '0;
        end
      sadc_pkg::SADC_CONVERT:
        if (conv_end)
        begin
          state_nxt = cs_s2_r ? sadc_pkg::SADC_TRACK : sadc_pkg::SADC_SLEEP;
          tmr_nxt = '0;
        end
      sadc_pkg::SADC_SLEEP:
      begin
        tmr_nxt = '0;
        if (cs_rise)
          state_nxt = sadc_pkg::SADC_WAKE;
      end
      sadc_pkg::SADC_WAKE:
        // hold after wake time, or at a later start fall
        if ((wake_end && !cs_s2_r) || (tmr_r >= CW'(WAKE_CYC - 1) && cs_fall))
        begin
          state_nxt = sadc_pkg::SADC_CONVERT;
          tmr_nxt = '0;
        end
        else if (tmr_r >= CW'(WAKE_CYC - 1))
          tmr_nxt = tmr_r;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_r <= sadc_pkg::SADC_TRACK;
      tmr_r <= '0;
    end
    else if (ce_i)
    begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  // busy drops after the conversion count
  // back to tracking at busy fall, or to sleep if convert start is still low
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      busy_r <= 1'b0;
      hold_r <= 1'b0;
      pd_r <= 1'b0;
      acq_r <= '0;
      acq_done_r <= 1'b1;
      code_r <= '0;
      push_r <= 1'b0;
    end
    else if (ce_i)
    begin
      busy_r <= (state_nxt == sadc_pkg::SADC_CONVERT);
      hold_r <= (state_nxt == sadc_pkg::SADC_CONVERT);
      pd_r <= (state_nxt == sadc_pkg::SADC_SLEEP);
      push_r <= conv_end;
      if (conv_end)
        code_r <= sar_code_i;
      // acquisition time status for the host
      if (conv_end)
      begin
        acq_r <= '0;
        acq_done_r <= 1'b0;
      end
      else if (!acq_done_r)
      begin
        acq_r <= acq_r + CW'(1);
        if (acq_r == CW'(ACQ_CYC - 1))
          acq_done_r <= 1'b1;
      end
    end
  end

  // Output shift register, counted by serial clock falling edges
  logic [4:0] bit_r;
  logic drive_r;
  logic sdo_r;
  wire [FB-1:0] frame = {{sadc_pkg::LEAD_ZEROS{1'b0}}, code_r.code};
  wire [4:0] bit_nxt = (bit_r == 5'(FB - 1)) ? 5'h00 : bit_r + 5'h01;
  wire [3:0] sel = 4'(FB - 1) - bit_r[3:0];

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      bit_r <= sadc_pkg::BITCNT_RST;
      drive_r <= 1'b0;
      sdo_r <= 1'b0;
    end
    else if (ce_i)
    begin
      // reset on start fall, serial clock low
      // a read spanning this edge is corrupted
      if (cs_fall && !sc_s2_r)
      begin
        bit_r <= sadc_pkg::BITCNT_RST;
        drive_r <= 1'b0;
        sdo_r <= 1'b0;
      end
      else if (sc_fall)
      begin
        bit_r <= bit_nxt;
        drive_r <= (bit_r != 5'(FB - 1));
        sdo_r <= (bit_r == 5'(FB - 1)) ? 1'b0 : frame[sel - 4'h1];
      end
      // First leading zero is driven once the read starts
      else if (sc_s2_r && !drive_r && bit_r == 5'h00)
      begin
        drive_r <= 1'b1;
        sdo_r <= frame[FB-1];
      end
    end
  end

  // Two-entry result stream; a word finishing while both entries are full is dropped
  logic buf_in_ready;
  sadc_pkg::sadc_word_t buf_data;
  logic buf_valid;
  sadc_buf2 #(
    .W(RB)
  ) u_buf (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .in_data_i(code_r.code),
    .in_valid_i(push_r),
    .in_ready_o(buf_in_ready),
    .out_data_o(buf_data),
    .out_valid_o(buf_valid),
    .out_ready_i(result_ready_i && result_valid_o)
  );

  // Registered stream outputs; pop only when the registered word is taken
  logic rv_r;
  sadc_pkg::sadc_word_t rd_r;
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rv_r <= 1'b0;
      rd_r <= '0;
    end
    else if (ce_i)
    begin
      rv_r <= buf_valid && !(result_ready_i && rv_r);
      rd_r <= buf_data;
    end
  end

  assign serial_result_out_o = sdo_r;
  assign serial_result_oe_n_o = !drive_r;
  assign busy_o = busy_r;
  assign hold_o = hold_r;
  assign power_down_o = pd_r;
  assign acq_done_o = acq_done_r;
  assign result_o = rd_r;
  assign result_valid_o = rv_r;
endmodule // sadc_ctrl
`default_nettype wire

// ### include/sadc_pkg.sv
// Purpose: Shared constants and types for the SAR converter control block
// Assumes: 250 MHz system clock
// Notes: Times kept in ns, cycle counts derived from the clock period
package sadc_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int RES_BITS = 12;
  localparam int FRAME_BITS = 16;
  localparam int LEAD_ZEROS = FRAME_BITS - RES_BITS;
  localparam int CONV_TIME_NS = 8000;
  localparam int WAKE_TIME_NS = 6000;
  localparam int ACQ_TIME_NS = 1500;
  // Longest times round down, least times round up
  localparam int CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int WAKE_CYC = WAKE_TIME_NS / CLK_PERIOD_NS;
  localparam int ACQ_CYC = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [RES_BITS-1:0] RESULT_RST = 12'h000;
  localparam logic [4:0] BITCNT_RST = 5'h00;

  typedef enum logic [2:0] {
    SADC_TRACK,
    SADC_CONVERT,
    SADC_SLEEP,
    SADC_WAKE
  } sadc_state_t;

  typedef struct packed {
    logic [RES_BITS-1:0] code;
  } sadc_word_t;
endpackage : sadc_pkg

// ### sim/sadc_ctrl_asserts.sv
// Purpose: Port checks for sadc_ctrl
// Assumes: One clock, async active-low reset
// Notes: Bounds allow for the pin sync delay
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl_chk #(
  parameter int CONV_CYC = 2000
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic convert_start_n_i,
  input wire logic serial_clk_i,
  input wire logic serial_result_oe_n_o,
  input wire logic busy_o,
  input wire logic hold_o,
  input wire logic power_down_o,
  input wire sadc_pkg::sadc_word_t result_o,
  input wire logic result_valid_o,
  input wire logic result_ready_i
);
  logic [15:0] bcnt_r;
  logic [3:0] fcnt_r;
  logic sck_r;
  logic cs_r;
  wire logic sfall = sck_r & ~serial_clk_i;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // Four-bit fall count wraps like the readout after the 16th pulse
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      bcnt_r <= 16'h0000;
      fcnt_r <= 4'h0;
      sck_r <= 1'b0;
      cs_r <= 1'b1;
    end
    else
    begin
      bcnt_r <= busy_o ? bcnt_r + 16'h0001 : 16'h0000;
      fcnt_r <= (cs_r & ~convert_start_n_i) ? 4'h0 : fcnt_r + {3'h0, sfall};
      sck_r <= serial_clk_i;
      cs_r <= convert_start_n_i;
    end
  end
  a_busy_on_start:
    assert property ($fell(convert_start_n_i) && !busy_o &&
      !$past(power_down_o, 8) |-> ##[2:6] busy_o) else $error("no busy");
  a_busy_length:
    assert property ($fell(busy_o) |-> bcnt_r == CONV_CYC) else $error("len");
  a_track_at_end:
    assert property ($fell(busy_o) |-> ##[0:1] !hold_o) else $error("hold");
  a_sleep_at_end:
    assert property ($fell(busy_o) && !convert_start_n_i &&
      !$past(convert_start_n_i, 4) |-> ##[0:2] power_down_o) else $error("pd");
  a_wake_no_hold:
    assert property ($rose(convert_start_n_i) && power_down_o |->
      !hold_o[*8]) else $error("early hold");
  a_oe_after_last:
    assert property (sfall && fcnt_r == 4'hF |-> ##7 serial_result_oe_n_o)
      else $error("oe on");
  a_oe_mid_read:
    assert property (sfall && fcnt_r != 4'hF |-> ##7 !serial_result_oe_n_o)
      else $error("oe off");
  a_word_held:
    assert property (result_valid_o && !result_ready_i |=> result_valid_o &&
      $stable(result_o)) else $error("word lost");
  c_conv: cover property ($fell(busy_o));
  c_sleep: cover property ($rose(power_down_o));
  c_stall: cover property (result_valid_o && !result_ready_i);
endmodule // sadc_ctrl_chk
bind sadc_ctrl sadc_ctrl_chk #(.CONV_CYC(CONV_CYC)) u_chk (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
  .convert_start_n_i(convert_start_n_i), .serial_clk_i(serial_clk_i),
  .serial_result_oe_n_o(serial_result_oe_n_o), .busy_o(busy_o),
  .hold_o(hold_o), .power_down_o(power_down_o), .result_o(result_o),
  .result_valid_o(result_valid_o), .result_ready_i(result_ready_i));
`default_nettype wire

// ### sim/sadc_host.sv
// Purpose: Host model: convert start and serial clock
// Assumes: Tasks are called on falling ref clock edges
// Notes: Serial clock idles low outside reads
`timescale 1ns/1ps
`default_nettype none
module sadc_host (
  input wire logic ref_clk_i,
  input wire logic sdo_i,
  output logic convert_start_n_o = 1'b1,
  output logic serial_clk_o = 1'b0
);
  task automatic drive_start(input logic v, input int cyc);
    convert_start_n_o = v;
    repeat (cyc) @(negedge ref_clk_i);
  endtask
  task automatic read(input int n, output logic [15:0] w);
    w = 16'h0000;
    repeat (n)
    begin
      serial_clk_o = 1'b1;
      repeat (6) @(negedge ref_clk_i);
      w = {w[14:0], sdo_i};
      serial_clk_o = 1'b0;
      repeat (6) @(negedge ref_clk_i);
    end
  endtask
endmodule // sadc_host
`default_nettype wire

// ### sim/test_sar_adc_conversion_and_serial_readout.sv
// Purpose: Self-checking bench for sadc_ctrl
// Assumes: 4 ns clock, 48 ns serial clock
// Notes: Counts cut to 20, 15 and 4 cycles
`timescale 1ns/1ps
`default_nettype none
module test_sar_adc_conversion_and_serial_readout;
  logic clk = 1'b0;
  logic nrst, rdy, sdo, oe_n, busy, hold, pd, vld, cs_n, sclk, sdo_last, acq;
  sadc_pkg::sadc_word_t code, res;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  // Released line shows the inverse of its last bit
  wire logic sdo_w = oe_n ? ~sdo_last : sdo;
  sadc_ctrl #(.CONV_CYC(20), .WAKE_CYC(15), .ACQ_CYC(4)) dut (
    .ref_clk_i(clk), .nrst_i(nrst), .ce_i(1'b1),
    .convert_start_n_i(cs_n), .serial_clk_i(sclk), .sar_code_i(code),
    .serial_result_out_o(sdo), .serial_result_oe_n_o(oe_n), .busy_o(busy),
    .hold_o(hold), .power_down_o(pd), .acq_done_o(acq), .result_o(res),
    .result_valid_o(vld), .result_ready_i(rdy));
  sadc_host host (.ref_clk_i(clk), .sdo_i(sdo_w),
    .convert_start_n_o(cs_n), .serial_clk_o(sclk));
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    if (!nrst)
      sdo_last <= 1'b0;
    else if (!oe_n)
      sdo_last <= sdo;
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wait_busy(input logic v, output int n);
    n = 0;
    while (busy !== v && n < 100)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic t_mode1(input logic [11:0] c);
    int n;
    logic [15:0] w;
    repeat (100) @(negedge clk);
    code.code = c;
    host.drive_start(1'b0, 6);
    chk("busy", 16'h1, 16'(busy));
    chk("hold", 16'h1, 16'(hold));
    host.drive_start(1'b1, 0);
    wait_busy(1'b0, n);
    chk("conv time", 16'h1, 16'(n > 12 && n <= 20));
    chk("track", 16'h0, 16'(hold));
    chk("acq wait", 16'h0, 16'(acq));
    repeat (6) @(negedge clk);
    chk("acq done", 16'h1, 16'(acq));
    host.read(16, w);
    chk("frame", {4'h0, c}, w);
    repeat (4) @(negedge clk);
    chk("oe_n", 16'h1, 16'(oe_n));
    $display("mode1 %h done", c);
  endtask
  task automatic t_extra;
    logic [15:0] w;
    host.read(1, w);
    chk("extra oe_n", 16'h0, 16'(oe_n));
    chk("extra bit", 16'h0, w);
    t_mode1(12'h5A3);
    $display("extra done");
  endtask
  task automatic t_sleep;
    int n;
    code.code = 12'h3C7;
    host.drive_start(1'b0, 40);
    chk("sleep", 16'h1, 16'(pd));
    host.drive_start(1'b1, 5);
    host.drive_start(1'b0, 8);
    chk("early hold", 16'h0, 16'(hold));
    repeat (8) @(negedge clk);
    chk("wake hold", 16'h1, 16'(hold));
    wait_busy(1'b0, n);
    chk("wake conv", 16'h1, 16'(n <= 22));
    host.drive_start(1'b1, 20);
    $display("sleep done");
  endtask
  task automatic t_buffer;
    rdy = 1'b0;
    t_mode1(12'h123);
    t_mode1(12'h456);
    t_mode1(12'h789);
    chk("valid", 16'h1, 16'(vld));
    chk("word0", 16'h0123, 16'(res.code));
    rdy = 1'b1;
    repeat (2) @(negedge clk);
    chk("valid1", 16'h1, 16'(vld));
    chk("word1", 16'h0456, 16'(res.code));
    @(negedge clk);
    chk("drained", 16'h0, 16'(vld));
    $display("buffer done");
  endtask
  task automatic t_overlap(input logic [11:0] c);
    int n;
    logic [15:0] w;
    logic [15:0] v;
    repeat (100) @(negedge clk);
    code.code = c;
    host.drive_start(1'b0, 6);
    host.drive_start(1'b1, 0);
    // First pulse taken while the conversion still runs
    host.read(1, w);
    chk("busy in read", 16'h1, 16'(busy));
    wait_busy(1'b0, n);
    repeat (6) @(negedge clk);
    host.read(15, v);
    chk("split frame", {4'h0, c}, {w[0], v[14:0]});
    $display("overlap done");
  endtask
  initial
  begin
    nrst = 1'b0;
    rdy = 1'b1;
    code.code = 12'h000;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    t_mode1(12'h000);
    t_mode1(12'hFFF);
    t_extra;
    t_sleep;
    t_buffer;
    t_overlap(12'hA5C);
    conclude();
  end
endmodule // test_sar_adc_conversion_and_serial_readout
`default_nettype wire
